//--- logic/i2cd_pkg.sv
`default_nettype none
package i2cd_pkg;
   localparam logic [11:0] BAUD_LOW_OFS   = 12'hF54;
   localparam logic [11:0] STATE_OBS_OFS  = 12'hF55;
   localparam logic [11:0] COUNTER_READBACK_SELECT_CTRL_OFS  = 12'hF56;
   localparam logic [7:0]  BAUD_LOW_RST   = 8'hFF;
   localparam logic        COUNTER_READBACK_SELECT_RST       = 1'h0;
   localparam int          COUNTER_READBACK_SELECT_SEL_BIT   = 0;
   localparam int          OBS_CLK_BIT    = 7;
   localparam int          OBS_DATA_BIT   = 6;
   localparam int          OBS_STOP_BIT   = 5;
   localparam int          OBS_STATE_MSB  = 4;
   localparam int          BAUD_WIDTH     = 16;

   typedef enum logic [4:0] {
      ST_IDLE    = 5'h00,
      ST_START   = 5'h01,
      ST_D7      = 5'h02,
      ST_D0      = 5'h09,
      ST_DACK    = 5'h0A,
      ST_DACK_NK = 5'h0B,
      ST_STOP1   = 5'h0C,
      ST_STOP2   = 5'h0D,
      ST_A_ACK   = 5'h0E,
      ST_A_B0    = 5'h0F,
      ST_X_B7    = 5'h10,
      ST_X_RW    = 5'h17,
      ST_X_ACK   = 5'h18,
      ST_A_B7    = 5'h19,
      ST_A_B1    = 5'h1F
   } i2cd_state_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } i2cd_req_t;
endpackage
`default_nettype wire

//--- logic/i2cd_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - baud low register holds reload bits 7..0, software read and write
// - with readback select set, low register reads live counter bits 7..0
// - readback select is counter_readback_select control bit 0; one selects counter readback
// - state observe register is read only; writes change nothing
// - observe bit 7 shows the sampled clock line
// - observe bit 6 shows the sampled data line
// - observe bit 5 shows the internal stop counter flag
// - observe bits 4..0 show the engine state code
// - data bits 7..0 step through codes 00010..01001, counting upward only
// - data ack is 01010; 01011 only while handling a not-acknowledge
// - stop passes 01100 then 01101
// - 01110 is the address acknowledge (second byte in ten-bit mode)
// - 01111 is address bit 0 / read-write bit
// - ten-bit first byte shifts through 10000..10111, last is read-write
// - ten-bit first byte acknowledge is 11000
// - address bits 7..1 use 11001..11111
module i2cd_top #(
   parameter int BAUD_W = i2cd_pkg::BAUD_WIDTH
) (
   input  wire logic                ref_clk_i,
   input  wire logic                resetn_i,
   input  wire logic                clk_en_i,
   input  wire i2cd_pkg::i2cd_req_t bus_req_i,
   input  wire logic [BAUD_W-9:0]   baud_reload_high_i,
   input  wire logic                engine_enable_i,
   input  wire logic                start_req_i,
   input  wire logic                stop_req_i,
   input  wire logic                ten_bit_i,
   input  wire logic                scl_i,
   input  wire logic                sda_i,
   output logic [7:0]               rdata_o,
   output logic [4:0]               state_code_o,
   output logic                     stop_counter_flag_o,
   output logic                     baud_tick_o,
   output logic                     counter_readback_select_o,
   output logic [BAUD_W-9:0]        baud_count_high_o
);
   if (BAUD_W < 9 || BAUD_W > 32) begin : g_chk
      $error("BAUD_W must lie between 9 and 32");
   end

   logic [7:0]            baud_reload_low;
   logic                  counter_readback_select;
   logic [BAUD_W-1:0]     baud_count;
   logic                  baud_tick;
   logic                  clock_line_sample;
   logic                  data_line_sample;
   logic                  stop_counter_flag;
   i2cd_pkg::i2cd_state_t state;
   i2cd_pkg::i2cd_state_t next_state;
   logic [7:0]            next_rdata;
   logic                  wr_low;
   logic                  wr_counter_readback_select;

   assign wr_low  = bus_req_i.wr && (bus_req_i.addr == i2cd_pkg::BAUD_LOW_OFS);
   assign wr_counter_readback_select = bus_req_i.wr && (bus_req_i.addr == i2cd_pkg::COUNTER_READBACK_SELECT_CTRL_OFS);

   // no write decode for the observe offset at all, so it cannot disturb state
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         baud_reload_low <= i2cd_pkg::BAUD_LOW_RST;
      end else if (clk_en_i && wr_low) begin
         baud_reload_low <= bus_req_i.wdata;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         counter_readback_select <= i2cd_pkg::COUNTER_READBACK_SELECT_RST;
      end else if (clk_en_i && wr_counter_readback_select) begin
         counter_readback_select <= bus_req_i.wdata[i2cd_pkg::COUNTER_READBACK_SELECT_SEL_BIT];
      end
   end

   // down counter; a reload of zero or one ticks every cycle
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         baud_count <= '1;
         baud_tick  <= 1'b0;
      end else if (clk_en_i) begin
         if (baud_count <= BAUD_W'(1)) begin
            baud_count <= {baud_reload_high_i, baud_reload_low};
            baud_tick  <= 1'b1;
         end else begin
            baud_count <= baud_count - BAUD_W'(1);
            baud_tick  <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         clock_line_sample <= 1'b1;
         data_line_sample  <= 1'b1;
      end else if (clk_en_i) begin
         clock_line_sample <= scl_i;
         data_line_sample  <= sda_i;
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         i2cd_pkg::ST_IDLE: begin
            if (start_req_i) begin
               next_state = i2cd_pkg::ST_START;
            end
         end
         i2cd_pkg::ST_START: begin
            next_state = ten_bit_i ? i2cd_pkg::ST_X_B7 : i2cd_pkg::ST_A_B7;
         end
         i2cd_pkg::ST_X_RW: begin
            next_state = i2cd_pkg::ST_X_ACK;
         end
         i2cd_pkg::ST_X_ACK: begin
            next_state = data_line_sample ? i2cd_pkg::ST_STOP1 : i2cd_pkg::ST_A_B7;
         end
         i2cd_pkg::ST_A_B1: begin
            next_state = i2cd_pkg::ST_A_B0;
         end
         i2cd_pkg::ST_A_B0: begin
            next_state = i2cd_pkg::ST_A_ACK;
         end
         i2cd_pkg::ST_A_ACK: begin
            next_state = data_line_sample ? i2cd_pkg::ST_STOP1 : i2cd_pkg::ST_D7;
         end
         i2cd_pkg::ST_D0: begin
            next_state = i2cd_pkg::ST_DACK;
         end
         i2cd_pkg::ST_DACK: begin
            if (data_line_sample) begin
               next_state = i2cd_pkg::ST_DACK_NK;
            end else if (stop_req_i) begin
               next_state = i2cd_pkg::ST_STOP1;
            end else if (start_req_i) begin
               next_state = i2cd_pkg::ST_START;
            end else begin
               next_state = i2cd_pkg::ST_D7;
            end
         end
         i2cd_pkg::ST_DACK_NK: begin
            next_state = i2cd_pkg::ST_STOP1;
         end
         i2cd_pkg::ST_STOP1: begin
            next_state = i2cd_pkg::ST_STOP2;
         end
         i2cd_pkg::ST_STOP2: begin
            next_state = i2cd_pkg::ST_IDLE;
         end
         default: begin
            // bit shifting runs: data, first and second address byte
            next_state = i2cd_pkg::i2cd_state_t'(state + 5'h01);
         end
      endcase
   end

   // the engine steps once per baud tick; disabling drops straight to idle
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= i2cd_pkg::ST_IDLE;
      end else if (clk_en_i) begin
         if (!engine_enable_i) begin
            state <= i2cd_pkg::ST_IDLE;
         end else if (baud_tick) begin
            state <= next_state;
         end
      end
   end

   // flag runs while a stop is being generated
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stop_counter_flag <= 1'b0;
      end else if (clk_en_i) begin
         stop_counter_flag <= (next_state == i2cd_pkg::ST_STOP1 || next_state == i2cd_pkg::ST_STOP2)
                              && engine_enable_i && baud_tick
                              || stop_counter_flag && (state == i2cd_pkg::ST_STOP1
                              || state == i2cd_pkg::ST_STOP2) && !(baud_tick && state == i2cd_pkg::ST_STOP2)
                              && engine_enable_i;
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      unique case (bus_req_i.addr)
         i2cd_pkg::BAUD_LOW_OFS: begin
            next_rdata = counter_readback_select ? baud_count[7:0] : baud_reload_low;
         end
         i2cd_pkg::STATE_OBS_OFS: begin
            next_rdata[i2cd_pkg::OBS_CLK_BIT]         = clock_line_sample;
            next_rdata[i2cd_pkg::OBS_DATA_BIT]        = data_line_sample;
            next_rdata[i2cd_pkg::OBS_STOP_BIT]        = stop_counter_flag;
            next_rdata[i2cd_pkg::OBS_STATE_MSB:0]     = state;
         end
         i2cd_pkg::COUNTER_READBACK_SELECT_CTRL_OFS: begin
            next_rdata[i2cd_pkg::COUNTER_READBACK_SELECT_SEL_BIT] = counter_readback_select;
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= 8'h00;
      end else if (clk_en_i) begin
         rdata_o <= bus_req_i.rd ? next_rdata : 8'h00;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_code_o              <= 5'h00;
         stop_counter_flag_o       <= 1'b0;
         baud_tick_o               <= 1'b0;
         counter_readback_select_o <= 1'b0;
         baud_count_high_o         <= '1;
      end else if (clk_en_i) begin
         state_code_o              <= state;
         stop_counter_flag_o       <= stop_counter_flag;
         baud_tick_o               <= baud_tick;
         counter_readback_select_o <= counter_readback_select;
         baud_count_high_o         <= baud_count[BAUD_W-1:8];
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   logic rd_low;
   logic rd_obs;
   assign rd_low = clk_en_i && bus_req_i.rd && bus_req_i.addr == i2cd_pkg::BAUD_LOW_OFS;
   assign rd_obs = clk_en_i && bus_req_i.rd && bus_req_i.addr == i2cd_pkg::STATE_OBS_OFS;

   a_low_reload_read: assert property (
      rd_low && !counter_readback_select |=> rdata_o == $past(baud_reload_low))
      else $error("baud low read does not return reload value");
   a_low_write_store: assert property (
      clk_en_i && wr_low |=> baud_reload_low == $past(bus_req_i.wdata))
      else $error("baud low write not stored");
   a_low_count_read: assert property (
      rd_low && counter_readback_select |=> rdata_o == $past(baud_count[7:0]))
      else $error("counter readback wrong");
   a_counter_readback_select_select: assert property (
      clk_en_i && wr_counter_readback_select |=> counter_readback_select == $past(bus_req_i.wdata[0]))
      else $error("readback select not written");
   a_obs_read_only: assert property (
      clk_en_i && bus_req_i.wr && bus_req_i.addr == i2cd_pkg::STATE_OBS_OFS
      |=> $stable(baud_reload_low) && $stable(counter_readback_select))
      else $error("observe write changed a register");
   a_obs_lines: assert property (
      rd_obs |=> rdata_o[7:6] == $past({clock_line_sample, data_line_sample}))
      else $error("line samples wrong in observe read");
   a_obs_stop_flag: assert property (
      rd_obs |=> rdata_o[5] == $past(stop_counter_flag))
      else $error("stop flag wrong in observe read");
   a_obs_state: assert property (
      rd_obs |=> rdata_o[4:0] == $past(state))
      else $error("state code wrong in observe read");
   a_idle_start: assert property (
      clk_en_i && engine_enable_i && baud_tick && state == i2cd_pkg::ST_IDLE && start_req_i
      |=> state == 5'h01)
      else $error("idle did not go to start");
   a_data_step: assert property (
      clk_en_i && engine_enable_i && baud_tick && state >= 5'h02 && state <= 5'h08
      |=> state == $past(state) + 5'h01)
      else $error("data bit state did not step");
   a_nak_entry: assert property (
      state == i2cd_pkg::ST_DACK_NK && $past(state) != i2cd_pkg::ST_DACK_NK
      |-> $past(state) == i2cd_pkg::ST_DACK && $past(data_line_sample))
      else $error("nak half entered without nak");
   a_stop_order: assert property (
      state == i2cd_pkg::ST_STOP2 && $past(state) != i2cd_pkg::ST_STOP2
      |-> $past(state) == i2cd_pkg::ST_STOP1)
      else $error("stop second part without first");
   a_addr_ack_path: assert property (
      state == i2cd_pkg::ST_A_ACK && $past(state) != i2cd_pkg::ST_A_ACK
      |-> $past(state) == i2cd_pkg::ST_A_B0)
      else $error("address ack not after bit 0");

   a_start_branch: assert property (
      clk_en_i && engine_enable_i && baud_tick && state == i2cd_pkg::ST_START
      |=> state == ($past(ten_bit_i) ? i2cd_pkg::ST_X_B7 : i2cd_pkg::ST_A_B7))
      else $error("start did not pick the address byte path");
   a_first_ack: assert property (
      clk_en_i && engine_enable_i && baud_tick && state == i2cd_pkg::ST_X_RW
      |=> state == i2cd_pkg::ST_X_ACK)
      else $error("first address byte ack not entered");
   a_addr_bit0: assert property (
      clk_en_i && engine_enable_i && baud_tick && state == i2cd_pkg::ST_A_B1
      |=> state == i2cd_pkg::ST_A_B0)
      else $error("address bit 0 not after bit 1");
   a_stop_flag_track: assert property (
      stop_counter_flag == (state == i2cd_pkg::ST_STOP1 || state == i2cd_pkg::ST_STOP2))
      else $error("stop flag out of step with stop states");

   c_ten_bit_ack: cover property (state == i2cd_pkg::ST_X_ACK);
   c_nak_seen:    cover property (state == i2cd_pkg::ST_DACK_NK);
   c_stop_done:   cover property (state == i2cd_pkg::ST_STOP2 ##1 state == i2cd_pkg::ST_IDLE);
   c_counter_readback_select_read:   cover property (rd_low && counter_readback_select);
endmodule
`default_nettype wire

//--- dv/i2cd_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2cd_slave_model (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [4:0] state_i,
   input  wire logic [1:0] nak_mode_i,
   input  wire logic [1:0] idle_pat_i,
   output logic            scl_o,
   output logic            sda_o
);
   logic busy;
   assign busy = (state_i != 5'h00);
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_o <= 1'b1;
      end else begin
         scl_o <= busy ? ~scl_o : idle_pat_i[1];
      end
   end
   // while busy the released data line sits at the pull-up, while idle it follows idle_pat_i[0]; acks pull it low
   always_comb begin
      sda_o = busy ? 1'b1 : idle_pat_i[0];
      if ((state_i == 5'h0E || state_i == 5'h18) && !nak_mode_i[0]) sda_o = 1'b0;
      if (state_i == 5'h0A && !nak_mode_i[1]) sda_o = 1'b0;
   end
endmodule
`default_nettype wire

//--- dv/i2cd_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2cd_top_tb;
   logic                ref_clk_i, resetn_i, clk_en_i, eng_en, start_req, stop_req, ten_bit, scl, sda;
   i2cd_pkg::i2cd_req_t req;
   logic [7:0]          rdata, d, v;
   logic [4:0]          st, prev_st;
   logic [1:0]          nk, pat;
   logic                stop_flag, tick, sel_o, cnt_hi;
   int                  num_errors, n_compared, n_ticks;

   i2cd_top #(.BAUD_W(9)) DUT (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i), .bus_req_i(req),
      .baud_reload_high_i(1'b0), .engine_enable_i(eng_en), .start_req_i(start_req),
      .stop_req_i(stop_req), .ten_bit_i(ten_bit), .scl_i(scl), .sda_i(sda), .rdata_o(rdata),
      .state_code_o(st), .stop_counter_flag_o(stop_flag), .baud_tick_o(tick),
      .counter_readback_select_o(sel_o), .baud_count_high_o(cnt_hi));
   i2cd_slave_model u_slave (
      .clk_i(ref_clk_i), .resetn_i(resetn_i), .state_i(st), .nak_mode_i(nk),
      .idle_pat_i(pat), .scl_o(scl), .sda_o(sda));

   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bw(input logic [11:0] a, input logic [7:0] wd);
      @(posedge ref_clk_i) req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_i) req.wr <= 1'b0;
   endtask
   task automatic br(input logic [11:0] a, output logic [7:0] q);
      @(posedge ref_clk_i) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_i) req.rd <= 1'b0;
      #1 q = rdata;
   endtask
   function automatic logic [7:0] nx(input logic [7:0] c, input logic [7:0] n);
      return (c <= 8'h01) ? n : c - 8'h01;
   endfunction
   function automatic logic [4:0] exp_next(input logic [4:0] s);
      case (s)
         5'h00: return 5'h01;
         5'h01: return ten_bit ? 5'h10 : 5'h19;
         5'h18: return nk[0] ? 5'h0C : 5'h19;
         5'h0E: return nk[0] ? 5'h0C : 5'h02;
         5'h1F: return 5'h0F;
         5'h0F: return 5'h0E;
         5'h0A: return nk[1] ? 5'h0B : stop_req ? 5'h0C : start_req ? 5'h01 : 5'h02;
         5'h0D: return 5'h00;
         default: return s + 5'h01;
      endcase
   endfunction

   // every visible step of the engine is compared with the documented order
   always @(posedge ref_clk_i) begin
      if (resetn_i && eng_en && st !== prev_st)
         check("state", {3'h0, st}, {3'h0, exp_next(prev_st)});
      prev_st <= st;
   end

   // bus traffic on the observe register while waiting; writes must not disturb it
   task automatic wait_st(input logic [4:0] code);
      for (int i = 0; i < 300 && st !== code; i++) begin
         if ($urandom % 4 == 0) bw(12'hF55, 8'($urandom));
         else begin
            br(12'hF55, d);
            check("obs_state", {3'h0, d[4:0]}, {3'h0, st});
            check("obs_stop", {7'h00, d[5]}, {7'h00, d[4:0] == 5'h0C || d[4:0] == 5'h0D});
         end
      end
      if (st !== code) check("wait_state", {3'h0, st}, {3'h0, code});
   endtask
   task automatic run(input logic tb, input logic [1:0] m, input logic sp);
      ten_bit <= tb;
      nk <= m;
      stop_req <= sp;
      wait_st(5'h0D);
      wait_st(5'h00);
   endtask

   task print_verdict;
      $display("compares=%0d errors=%0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #(5 * 30000);
      num_errors++;
      print_verdict();
   end

   initial begin
      resetn_i = 1'b0; clk_en_i = 1'b1; eng_en = 1'b0; start_req = 1'b0; stop_req = 1'b0;
      ten_bit = 1'b0; nk = 2'h0; pat = 2'h3; req = '0;
      num_errors = 0; n_compared = 0;
      void'($urandom(75));
      repeat (20) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      br(12'hF54, d); check("baud_low_rst", d, 8'hFF);
      br(12'hF56, d); check("counter_readback_select_rst", d, 8'h00);
      for (int i = 0; i < 6; i++) begin
         v = 8'($urandom);
         bw(12'hF54, v);
         bw(12'hF57, ~v);
         br(12'hF57, d); check("unmapped", d, 8'h00);
         br(12'hF54, d); check("baud_low", d, v);
         pat <= 2'($urandom);
         bw(12'hF55, v);
         repeat (3) @(posedge ref_clk_i);
         br(12'hF55, d); check("obs_idle", d, {pat, 6'h00});
      end
      pat <= 2'h3;
      bw(12'hF54, 8'h07);
      repeat (600) @(posedge ref_clk_i);
      // reload of seven gives exactly ten ticks in any seventy cycles
      n_ticks = 0;
      repeat (70) begin
         @(posedge ref_clk_i);
         #1 if (tick === 1'b1) n_ticks++;
      end
      check("tick_count", 8'(n_ticks), 8'h0A);
      bw(12'hF56, 8'h01);
      br(12'hF56, d); check("counter_readback_select", d, 8'h01);
      check("sel_out", {7'h00, sel_o}, 8'h01);
      for (int i = 0; i < 3; i++) begin
         br(12'hF54, v);
         br(12'hF54, d); check("counter", d, nx(nx(v, 8'h07), 8'h07));
         check("count_high", {7'h00, cnt_hi}, 8'h00);
      end
      bw(12'hF56, 8'h00);
      br(12'hF54, d); check("reload_back", d, 8'h07);
      check("sel_clear", {7'h00, sel_o}, 8'h00);
      // reload of four leaves the partner time to settle its ack
      bw(12'hF54, 8'h04);
      eng_en <= 1'b1;
      start_req <= 1'b1;
      run(1'b0, 2'h0, 1'b1);
      run(1'b1, 2'h0, 1'b1);
      run(1'b0, 2'h1, 1'b1);
      run(1'b1, 2'h1, 1'b1);
      run(1'b0, 2'h2, 1'b1);
      ten_bit <= 1'b0;
      nk <= 2'h0;
      stop_req <= 1'b0;
      wait_st(5'h0A);
      wait_st(5'h01);
      // let the step checker judge the repeated start before the requests move
      repeat (2) @(posedge ref_clk_i);
      // neither start nor stop at the next data ack: a further byte follows
      start_req <= 1'b0;
      wait_st(5'h0A);
      wait_st(5'h05);
      stop_req <= 1'b1;
      start_req <= 1'b1;
      wait_st(5'h0D);
      @(posedge ref_clk_i) clk_en_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      v = {3'h0, st};
      repeat (10) @(posedge ref_clk_i);
      check("frozen", {3'h0, st}, v);
      clk_en_i <= 1'b1;
      wait_st(5'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
